// ==== src/shci_regs.svh ====
// offsets, field positions, reset values and counts of the serial host port
`ifndef SHCI_REGS_SVH
`define SHCI_REGS_SVH

// full extended address of the local configuration register
`define SHCI_CFG_ADDR        23'h00_0000
// field positions inside the configuration data word
`define SHCI_CFG_UNIT_LSB    0
`define SHCI_CFG_PTDIS_BIT   8
`define SHCI_CFG_BUSTHRU_BIT 9
// configuration reset value: pass-through on, unit address zero
`define SHCI_CFG_RESET       7'h00
// shift-clock falls between last command bit and first read bit
`define SHCI_RD_DELAY        4
// index of the last bit of a 16-bit word
`define SHCI_LAST_BIT        4'hf

`endif

// ==== src/shci_pkg.sv ====
// types shared by the serial host chain interface
package shci_pkg;

	// command word, bit 15 first
	typedef struct packed {
		logic       rw;
		logic       bcast;
		logic       ext;
		logic       inc;
		logic [4:0] unit;
		logic [6:0] addr;
	} shci_cmd_type;

	// local configuration held by the port itself
	typedef struct packed {
		logic       bus_thru;
		logic       pt_dis;
		logic [4:0] unit;
	} shci_cfg_type;

	// transaction sequencer, one-hot
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b00_0001,
		ST_CMD    = 6'b00_0010,
		ST_EXT    = 6'b00_0100,
		ST_WDATA  = 6'b00_1000,
		ST_RDELAY = 6'b01_0000,
		ST_RDATA  = 6'b10_0000
	} shci_state_type;

endpackage : shci_pkg

// ==== src/shci_top.sv ====
// serial host chain interface: command decode, chaining and read shifter
// Notes on behaviour
// - access is command word then data words
// - chip select fall starts, rise ends access
// - input bits taken on shift-clock rise, select low
// - read bits driven on shift-clock fall
// - after reset output copies input unclocked; the code copies it through three core-clock registers
// - pass-through read puts register data out
// - pass-through disabled holds output high
// - enable change acts within two shift clocks
// - floating mode: output off while deselected
// - floating mode: follow input, read data out
// - first sixteen bits after select are command
// - bit 15 set reads, clear writes
// - bit 14 broadcast write ignores unit address
// - bit 13 adds sixteen address bits
// - bit 12 increments address per word
// - bits 11..7 must match unit address
// - unit address resets to zero
// - bits 6..0 give register address
// - register 0 holds disable and unit address
// - four shift clocks before read data
`timescale 1ns/1ps
`default_nettype none
`include "shci_regs.svh"

module shci_top #(
	parameter int ADDR_W = 23,
	parameter int WORD_W = 16
) (
	input  wire logic              core_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic              cs_n_i,
	input  wire logic              sclk_i,
	input  wire logic              serial_in_pin_i,
	output var  logic              serial_out_pin_o,
	output var  logic              serial_out_pin_oe_o,
	output var  logic              wr_valid_o,
	output var  logic [ADDR_W-1:0] wr_addr_o,
	output var  logic [WORD_W-1:0] wr_data_o,
	output var  logic              rd_req_o,
	output var  logic [ADDR_W-1:0] rd_addr_o,
	input  wire logic [WORD_W-1:0] rd_data_i,
	output var  logic              passthrough_disable_o,
	output var  logic              bus_through_o,
	output var  logic [4:0]        unit_addr_o
);

	// pin synchronisers plus one history stage for edge finding
	logic cs_s1_reg, cs_s2_reg, cs_d_reg;
	logic ck_s1_reg, ck_s2_reg, ck_d_reg;
	logic di_s1_reg, di_s2_reg;

	shci_pkg::shci_state_type state_reg, state_next;
	shci_pkg::shci_cmd_type   cmd_reg, cmd_next;
	shci_pkg::shci_cfg_type   cfg_reg, cfg_next;
	logic [3:0]        bit_cnt_reg, bit_cnt_next;
	logic [1:0]        dly_reg, dly_next;
	logic [WORD_W-1:0] shift_reg, shift_next;
	logic [WORD_W-1:0] out_reg, out_next;
	logic [WORD_W-1:0] rd_word_reg;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic              rd_req_next;
	logic              wr_next;
	logic              sdo_next, oe_next;

	// link events, all seen through the synchronised copies
	wire sclk_rise = ck_s2_reg & ~ck_d_reg & ~cs_s2_reg;
	wire sclk_fall = ~ck_s2_reg & ck_d_reg & ~cs_s2_reg;
	wire cs_fall   = ~cs_s2_reg & cs_d_reg;
	wire [WORD_W-1:0] rx_word = {shift_reg[WORD_W-2:0], di_s2_reg};
	wire rx_rise   = sclk_rise & (state_reg != shci_pkg::ST_RDATA);
	wire word_done = rx_rise & (bit_cnt_reg == `SHCI_LAST_BIT);
	wire shci_pkg::shci_cmd_type cmd_in = rx_word;
	// broadcast only widens writes; a read always needs its own unit
	wire cmd_match = (cmd_in.unit == cfg_reg.unit) |
		(cmd_in.bcast & ~cmd_in.rw);
	wire is_cfg    = (addr_reg == `SHCI_CFG_ADDR);
	wire drive_rd  = (state_reg == shci_pkg::ST_RDATA) & ~cs_s2_reg;
	wire dly_last  = (dly_reg == 2'(`SHCI_RD_DELAY - 1));
	wire [ADDR_W-1:0] addr_inc = addr_reg + 23'h1;
	wire [WORD_W-1:0] cfg_word =
		(16'(cfg_reg.unit) << `SHCI_CFG_UNIT_LSB) |
		(16'(cfg_reg.pt_dis) << `SHCI_CFG_PTDIS_BIT) |
		(16'(cfg_reg.bus_thru) << `SHCI_CFG_BUSTHRU_BIT);
	assign passthrough_disable_o = cfg_reg.pt_dis;
	assign bus_through_o         = cfg_reg.bus_thru;
	assign unit_addr_o           = cfg_reg.unit;
	assign rd_addr_o             = addr_reg;

	// synchronisers: the first stage feeds only the second
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_d_reg  <= 1'b1;
			ck_s1_reg <= 1'b0;
			ck_s2_reg <= 1'b0;
			ck_d_reg  <= 1'b0;
			di_s1_reg <= 1'b1;
			di_s2_reg <= 1'b1;
		end else if (ce_i) begin
			cs_s1_reg <= cs_n_i;
			cs_s2_reg <= cs_s1_reg;
			cs_d_reg  <= cs_s2_reg;
			ck_s1_reg <= sclk_i;
			ck_s2_reg <= ck_s1_reg;
			ck_d_reg  <= ck_s2_reg;
			di_s1_reg <= serial_in_pin_i;
			di_s2_reg <= di_s1_reg;
		end
	end

	// sequencer: command, optional address extension, data words
	always_comb begin
		state_next   = state_reg;
		cmd_next     = cmd_reg;
		cfg_next     = cfg_reg;
		bit_cnt_next = bit_cnt_reg;
		dly_next     = dly_reg;
		shift_next   = shift_reg;
		out_next     = out_reg;
		addr_next    = addr_reg;
		rd_req_next  = 1'b0;
		wr_next      = 1'b0;
		if (cs_s2_reg) begin
			state_next = shci_pkg::ST_IDLE;
		end else if (cs_fall) begin
			state_next   = shci_pkg::ST_CMD;
			bit_cnt_next = 4'h0;
		end else if (rx_rise) begin
			shift_next   = rx_word;
			bit_cnt_next = bit_cnt_reg + 4'h1;
		end
		if (!cs_s2_reg && !cs_fall && word_done) begin
			case (state_reg)
			shci_pkg::ST_CMD: begin
				cmd_next  = cmd_in;
				addr_next = {16'h0000, cmd_in.addr};
				dly_next  = 2'h0;
				if (!cmd_match) begin
					state_next = shci_pkg::ST_IDLE;
				end else if (cmd_in.ext) begin
					state_next = shci_pkg::ST_EXT;
				end else if (cmd_in.rw) begin
					state_next  = shci_pkg::ST_RDELAY;
					rd_req_next = 1'b1;
				end else begin
					state_next = shci_pkg::ST_WDATA;
				end
			end
			shci_pkg::ST_EXT: begin
				addr_next = {rx_word, cmd_reg.addr};
				dly_next  = 2'h0;
				if (cmd_reg.rw) begin
					state_next  = shci_pkg::ST_RDELAY;
					rd_req_next = 1'b1;
				end else begin
					state_next = shci_pkg::ST_WDATA;
				end
			end
			shci_pkg::ST_WDATA: begin
				wr_next = 1'b1;
				if (is_cfg) begin
					cfg_next.unit =
						rx_word[`SHCI_CFG_UNIT_LSB +: 5];
					cfg_next.pt_dis =
						rx_word[`SHCI_CFG_PTDIS_BIT];
					cfg_next.bus_thru =
						rx_word[`SHCI_CFG_BUSTHRU_BIT];
				end
				if (cmd_reg.inc) begin
					addr_next = addr_inc;
				end else begin
					state_next = shci_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = state_reg;
			end
			endcase
		end
		if (sclk_fall && !cs_fall) begin
			case (state_reg)
			shci_pkg::ST_RDELAY: begin
				dly_next = dly_reg + 2'h1;
				if (dly_last) begin
					state_next   = shci_pkg::ST_RDATA;
					out_next     = rd_word_reg;
					bit_cnt_next = 4'h0;
					if (cmd_reg.inc) begin
						addr_next   = addr_inc;
						rd_req_next = 1'b1;
					end
				end
			end
			shci_pkg::ST_RDATA: begin
				bit_cnt_next = bit_cnt_reg + 4'h1;
				out_next     = {out_reg[WORD_W-2:0], 1'b0};
				if (bit_cnt_reg == `SHCI_LAST_BIT) begin
					if (cmd_reg.inc) begin
						out_next    = rd_word_reg;
						addr_next   = addr_inc;
						rd_req_next = 1'b1;
					end else begin
						state_next = shci_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				dly_next = dly_reg;
			end
			endcase
		end
	end

	// serial output select; registered so a config change lands in
	// one core cycle, far inside the two shift-clock command gap
	always_comb begin
		sdo_next = di_s2_reg;
		oe_next  = 1'b1;
		if (drive_rd) begin
			sdo_next = out_reg[WORD_W-1];
		end else if (cfg_reg.bus_thru) begin
			oe_next = ~cs_s2_reg;
		end else if (cfg_reg.pt_dis) begin
			sdo_next = 1'b1;
		end
	end

	// sequencer and configuration registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_reg   <= shci_pkg::ST_IDLE;
			cmd_reg     <= '0;
			cfg_reg     <= `SHCI_CFG_RESET;
			bit_cnt_reg <= 4'h0;
			dly_reg     <= 2'h0;
			shift_reg   <= '0;
			out_reg     <= '0;
			addr_reg    <= '0;
		end else if (ce_i) begin
			state_reg   <= state_next;
			cmd_reg     <= cmd_next;
			cfg_reg     <= cfg_next;
			bit_cnt_reg <= bit_cnt_next;
			dly_reg     <= dly_next;
			shift_reg   <= shift_next;
			out_reg     <= out_next;
			addr_reg    <= addr_next;
		end
	end

	// register-side strobes and read capture (local config served here)
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rd_req_o            <= 1'b0;
			rd_word_reg         <= '0;
			wr_valid_o          <= 1'b0;
			wr_addr_o           <= '0;
			wr_data_o           <= '0;
			serial_out_pin_o    <= 1'b1;
			serial_out_pin_oe_o <= 1'b1;
		end else if (ce_i) begin
			rd_req_o            <= rd_req_next;
			if (rd_req_o) begin
				rd_word_reg <= is_cfg ? cfg_word : rd_data_i;
			end
			wr_valid_o          <= wr_next;
			if (wr_next) begin
				wr_addr_o <= addr_reg;
				wr_data_o <= rx_word;
			end
			serial_out_pin_o    <= sdo_next;
			serial_out_pin_oe_o <= oe_next;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence cs_start_s;
		ce_i && cs_fall;
	endsequence

	sequence cmd_read_s;
		ce_i && word_done && state_reg == shci_pkg::ST_CMD &&
			cmd_match && cmd_in.rw && !cmd_in.ext && !cs_s2_reg;
	endsequence

	cmd_start_a: assert property (cs_start_s |=>
		state_reg == shci_pkg::ST_CMD && bit_cnt_reg == 4'h0)
		else $error("command phase not opened by select fall");
	cs_end_a: assert property (ce_i && cs_s2_reg |=>
		state_reg == shci_pkg::ST_IDLE)
		else $error("transaction survived select rise");
	read_req_a: assert property (cmd_read_s |=>
		rd_req_o && state_reg == shci_pkg::ST_RDELAY)
		else $error("read command did not request data");
	copy_in_a: assert property (ce_i && !drive_rd &&
		!cfg_reg.bus_thru && !cfg_reg.pt_dis |=>
		serial_out_pin_o == $past(di_s2_reg) && serial_out_pin_oe_o)
		else $error("pass-through output does not copy input");
	link_off_a: assert property (ce_i && !drive_rd &&
		!cfg_reg.bus_thru && cfg_reg.pt_dis |=>
		serial_out_pin_o && serial_out_pin_oe_o)
		else $error("disabled pass-through output not high");
	float_off_a: assert property (ce_i && cfg_reg.bus_thru &&
		cs_s2_reg |=> !serial_out_pin_oe_o)
		else $error("floating output driven while deselected");
	float_follow_a: assert property (ce_i && cfg_reg.bus_thru &&
		!cs_s2_reg && !drive_rd |=> serial_out_pin_oe_o &&
		serial_out_pin_o == $past(di_s2_reg))
		else $error("floating output does not follow input");
	read_out_a: assert property (ce_i && drive_rd |=>
		serial_out_pin_o == $past(out_reg[WORD_W-1]))
		else $error("read bit not on output");
	read_gap_a: assert property (ce_i && sclk_fall && !dly_last &&
		state_reg == shci_pkg::ST_RDELAY |=>
		state_reg == shci_pkg::ST_RDELAY)
		else $error("read data started before four shift clocks");
	write_skip_a: assert property (ce_i && word_done &&
		state_reg == shci_pkg::ST_CMD && !cmd_match && !cs_s2_reg
		|=> state_reg == shci_pkg::ST_IDLE ##1 !wr_valid_o)
		else $error("unmatched unit went on to data");
	auto_inc_a: assert property (ce_i && word_done && !cs_s2_reg &&
		state_reg == shci_pkg::ST_WDATA && cmd_reg.inc |=>
		addr_reg == $past(addr_inc) && wr_valid_o)
		else $error("write address did not increment");
	unit_reset_a: assert property (disable iff (1'b0)
		!rst_n_i |=> cfg_reg == `SHCI_CFG_RESET)
		else $error("unit address not zero after reset");

endmodule : shci_top
`default_nettype wire

// ==== src/shci_top_note_unused.sv ====
// holds no logic: the whole serial host port lives in shci_top

// ==== test/shci_host_model.sv ====
// host side model that drives the serial port of the chain interface
`timescale 1ns/1ps
`default_nettype none

module shci_host_model (
	input  wire logic core_clk_i,
	output var  logic cs_n_o, // one device on this select
	output var  logic sclk_o,
	output var  logic sdi_o,
	input  wire logic sdo_i
);
	// idle deselected, shift clock parked high
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b1;
		sdi_o  = 1'b1;
	end

	// select falls while the shift clock is high, so no stray edge
	task automatic sel();
		@(posedge core_clk_i);
		cs_n_o <= 1'b0;
		repeat (4) @(posedge core_clk_i);
	endtask : sel

	// n bits msb first, 8 core cycles per bit keeps the rate low
	task automatic word(input logic [15:0] tx, input int n,
		output logic [15:0] rx);
		rx = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			sclk_o <= 1'b0;
			sdi_o  <= tx[i];
			repeat (4) @(posedge core_clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			rx[i] = sdo_i; // late in the bit, read bit has settled
		end
	endtask : word

	// release: data line gets the inverse so a stale level never passes
	task automatic desel();
		repeat (4) @(posedge core_clk_i);
		cs_n_o <= 1'b1;
		sdi_o  <= ~sdi_o;
		repeat (20) @(posedge core_clk_i); // over two shift clocks of gap
	endtask : desel

	// static level on the data line while deselected
	task automatic put(input logic b);
		sdi_o <= b;
		repeat (6) @(posedge core_clk_i);
	endtask : put
endmodule : shci_host_model
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the serial host chain interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
	err_total++; $display("unexpected %s exp %h got %h", n, e, a); end end

module tb;
	logic        clk, rst_n, cs_n, sclk, serial_in_pin, serial_out_pin, oe, wv, rq, pd, bt;
	logic [22:0] wa, ra;
	logic [15:0] wd, rd;
	logic [4:0]  ua;
	wire         sdo_w;
	int          err_total, check_count, wr_cnt, rd_cnt;

	// register side answers with an address-derived pattern
	assign rd    = {9'h000, ra[6:0]} ^ 16'ha5a5;
	assign sdo_w = oe ? serial_out_pin : 1'b1; // pull-up when released
	shci_top i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
		.cs_n_i(cs_n), .sclk_i(sclk), .serial_in_pin_i(serial_in_pin),
		.serial_out_pin_o(serial_out_pin), .serial_out_pin_oe_o(oe), .wr_valid_o(wv),
		.wr_addr_o(wa), .wr_data_o(wd), .rd_req_o(rq), .rd_addr_o(ra),
		.rd_data_i(rd), .passthrough_disable_o(pd), .bus_through_o(bt),
		.unit_addr_o(ua));
	shci_host_model i_host (.core_clk_i(clk), .cs_n_o(cs_n),
		.sclk_o(sclk), .sdi_o(serial_in_pin), .sdo_i(sdo_w));

	// clock and write and read strobe counters
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (wv === 1'b1) wr_cnt++;
	always @(posedge clk) if (rq === 1'b1) rd_cnt++;

	function automatic logic [15:0] cmd(input logic [3:0] f,
		input logic [4:0] u, input logic [6:0] a);
		return {f, u, a};
	endfunction : cmd

	task automatic wr1(input logic [15:0] c, input logic [15:0] d);
		logic [15:0] x;
		i_host.sel();
		i_host.word(c, 16, x);
		i_host.word(d, 16, x);
		i_host.desel();
	endtask : wr1

	// read: three pad bits cover the four-fall gap, then two words
	task automatic rd2(input logic [15:0] c, output logic [15:0] r0,
		output logic [15:0] r1);
		logic [15:0] x;
		i_host.sel();
		i_host.word(c, 16, x);
		i_host.word(16'h0000, 3, x);
		i_host.word(16'h0000, 16, r0);
		i_host.word(16'h0000, 16, r1);
		i_host.desel();
	endtask : rd2

	task automatic t_reset();
		`CHK("unit", 5'h00, ua)
		`CHK("pt_dis", 1'b0, pd)
		i_host.put(1'b0);
		`CHK("copy", 1'b0, serial_out_pin)
		i_host.put(1'b1);
		`CHK("copy", 1'b1, serial_out_pin)
		$display("t_reset done");
	endtask : t_reset

	task automatic t_unit();
		int n;
		n = wr_cnt;
		wr1(cmd(4'h0, 5'h00, 7'h00), 16'h0105);
		`CHK("wr count", n + 1, wr_cnt)
		`CHK("wr addr", 23'h00_0000, wa)
		`CHK("unit", 5'h05, ua)
		`CHK("pt_dis", 1'b1, pd)
		i_host.put(1'b0);
		`CHK("held", 1'b1, serial_out_pin)
		wr1(cmd(4'h0, 5'h00, 7'h12), 16'h1234);
		`CHK("wr count", n + 1, wr_cnt)
		`CHK("held", 1'b1, serial_out_pin)
		wr1(cmd(4'h4, 5'h03, 7'h12), 16'h1234);
		`CHK("wr count", n + 2, wr_cnt)
		`CHK("wr addr", 23'h00_0012, wa)
		wr1(cmd(4'h0, 5'h05, 7'h00), 16'h0005);
		`CHK("pt_dis", 1'b0, pd)
		$display("t_unit done");
	endtask : t_unit

	task automatic t_read();
		logic [15:0] r0, r1;
		int n;
		n = rd_cnt;
		rd2(cmd(4'h8, 5'h05, 7'h00), r0, r1);
		`CHK("cfg read", 16'h0005, r0)
		`CHK("rd count", n + 1, rd_cnt)
		rd2(cmd(4'h9, 5'h05, 7'h10), r0, r1);
		`CHK("inc read 0", 16'ha5b5, r0)
		`CHK("inc read 1", 16'ha5b4, r1)
		`CHK("inc addr", 23'h00_0012, ra)
		$display("t_read done");
	endtask : t_read

	// auto-increment write of two words from one command
	task automatic t_burst();
		logic [15:0] x;
		int n;
		n = wr_cnt;
		i_host.sel();
		i_host.word(cmd(4'h1, 5'h05, 7'h30), 16, x);
		i_host.word(16'h1111, 16, x);
		i_host.word(16'h2222, 16, x);
		i_host.desel();
		`CHK("burst count", n + 2, wr_cnt)
		`CHK("burst addr", 23'h00_0031, wa)
		`CHK("burst data", 16'h2222, wd)
		$display("t_burst done");
	endtask : t_burst

	task automatic t_float();
		logic [15:0] x, r0, r1;
		i_host.sel();
		i_host.word(cmd(4'h2, 5'h05, 7'h03), 16, x);
		i_host.word(16'h0abc, 16, x);
		i_host.word(16'h5a5a, 16, x);
		i_host.desel();
		`CHK("ext addr", 23'h05_5e03, wa)
		`CHK("ext data", 16'h5a5a, wd)
		wr1(cmd(4'h0, 5'h05, 7'h00), 16'h0205);
		`CHK("float", 1'b1, bt)
		`CHK("oe idle", 1'b0, oe)
		i_host.sel();
		repeat (4) @(posedge clk);
		`CHK("oe sel", 1'b1, oe)
		i_host.word(cmd(4'h0, 5'h05, 7'h20), 16, x);
		`CHK("follow", 1'b0, serial_out_pin)
		i_host.word(16'h0001, 16, x);
		`CHK("follow", 1'b1, serial_out_pin)
		i_host.desel();
		`CHK("oe idle", 1'b0, oe)
		rd2(cmd(4'h8, 5'h05, 7'h00), r0, r1);
		`CHK("float read", 16'h0205, r0)
		$display("t_float done");
	endtask : t_float

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	// watchdog well beyond the few thousand cycles the tests need
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		end_sim();
	end

	// reset for four cycles, let the synchronisers fill, then run
	initial begin
		err_total   = 0;
		check_count = 0;
		wr_cnt      = 0;
		rd_cnt      = 0;
		rst_n       = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_reset();
		t_unit();
		t_read();
		t_burst();
		t_float();
		end_sim();
	end
endmodule : tb
`default_nettype wire
